// *** hw/lbcs_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lbcs_defines.svh"

module lbcs_bank
    import lbcs_pkg::*;
#(
    parameter int ROW_W = 13
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             sel,
    input  wire logic [2:0]       cmd,
    input  wire logic             ap,
    input  wire logic             pre_all,
    input  wire logic [ROW_W-1:0] row,
    input  wire logic             burst_done,
    input  wire logic             bst_hit,
    output lbcs_bank_t            state_q,
    output logic [ROW_W-1:0]      row_q,
    output logic                  illegal
);
    localparam logic [3:0] TRP  = 4'(`LBCS_TRP_CYC);
    localparam logic [3:0] TRCD = 4'(`LBCS_TRCD_CYC);

    lbcs_bank_t       state_d;
    logic [ROW_W-1:0] row_d;
    logic [3:0]       cnt_q;
    logic [3:0]       cnt_d;

    always_comb begin
        state_d = state_q;
        row_d   = row_q;
        cnt_d   = (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
        illegal = 1'b0;
        // Precharge all reaches non-idle banks, judged per bank; one ending its activate delay, or unaddressed and ending a read/write burst, goes row active
        if (pre_all && state_q != LBCS_IDLE) begin
            state_d = LBCS_PRECHARGING;
            cnt_d   = TRP;
        end
        unique case (state_q)
            LBCS_IDLE: begin
                if (sel && cmd == `LBCS_CMD_ACT) begin
                    state_d = LBCS_ACTIVATING;
                    row_d   = row;
                    cnt_d   = TRCD;
                end else if (sel && cmd != `LBCS_CMD_NOP
                             && cmd != `LBCS_CMD_PRE) begin
                    illegal = 1'b1;
                end
            end
            LBCS_ACTIVATING, LBCS_PRECHARGING: begin
                if (cnt_q <= 4'h1)
                    state_d = (state_q == LBCS_ACTIVATING) ?
                              LBCS_ROW_ACTIVE : LBCS_IDLE;
                if (sel && cmd != `LBCS_CMD_NOP)
                    illegal = 1'b1;
            end
            LBCS_ROW_ACTIVE, LBCS_READ, LBCS_WRITE: begin
                if (state_q != LBCS_ROW_ACTIVE && burst_done)
                    state_d = LBCS_ROW_ACTIVE;
                if (bst_hit && state_q == LBCS_READ)
                    state_d = LBCS_ROW_ACTIVE;
                if (sel) begin
                    unique case (cmd)
                        `LBCS_CMD_READ: state_d = ap ? LBCS_AP_ACCESS
                                                     : LBCS_READ;
                        `LBCS_CMD_WRITE: state_d = ap ? LBCS_AP_ACCESS
                                                      : LBCS_WRITE;
                        `LBCS_CMD_PRE: begin
                            state_d = LBCS_PRECHARGING;
                            cnt_d   = TRP;
                        end
                        `LBCS_CMD_NOP: ;
                        `LBCS_CMD_BST: illegal = (state_q != LBCS_READ);
                        default: illegal = 1'b1;
                    endcase
                end
            end
            LBCS_AP_ACCESS: begin
                // Auto precharge closes the row after the burst
                if (burst_done) begin
                    state_d = LBCS_PRECHARGING;
                    cnt_d   = TRP;
                end
                if (sel && cmd != `LBCS_CMD_NOP)
                    illegal = 1'b1;
            end
            default: state_d = LBCS_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= LBCS_IDLE;
            row_q   <= `LBCS_ROW_RST;
            cnt_q   <= 4'h0;
        end else begin
            state_q <= state_d;
            row_q   <= row_d;
            cnt_q   <= cnt_d;
        end
    end
endmodule : lbcs_bank
`default_nettype wire

// *** hw/lbcs_ctrl.sv ***
// What this block does
// - Burst terminate cuts the latest non-auto-precharge read burst only.
// - After burst terminate the read row stays open.
// - Auto refresh row comes from internal counter; address ignored.
// - Auto refresh keeps device busy for refresh cycle time.
// - Refresh encoding with clock enable low enters self refresh.
// - In self refresh all inputs but clock enable are ignored.
// - Terminate encoding with clock enable low enters array power off.
// - Array power off loses all stored data.
// - Deselect or no-operation starts nothing; ongoing work continues.
// - Idle bank accepts activate and precharge; auto refresh, load mode register run but flag illegal.
// - Row active bank accepts read, write and precharge.
// - Read burst accepts read, write, terminate, precharge.
// - Write burst accepts read, write, precharge.
// - Bank rules apply only with clock enable high two cycles.
// - Idle after precharge time; row active after activate delay.
// - Read or write state lasts until burst completes or ends.
// - Precharging and activating states end after their delays.
// - Legality is tracked per addressed bank, global commands included.
`timescale 1ns/1ps
`default_nettype none
`include "lbcs_defines.svh"

module lbcs_ctrl
    import lbcs_pkg::*;
#(
    parameter int NBANK = 4,
    parameter int ROW_W = 13,
    parameter int BL    = 4
) (
    input  wire logic                     clock,
    input  wire logic                     rst_b,
    input  wire logic                     cke,
    input  wire logic                     cs_b,
    input  wire logic                     ras_b,
    input  wire logic                     cas_b,
    input  wire logic                     we_b,
    input  wire logic [1:0]               bank_addr,
    input  wire logic [ROW_W-1:0]         addr,
    output logic [3*NBANK-1:0]            bank_state,
    output logic [ROW_W-1:0]              refresh_row,
    output logic                          refresh_busy,
    output logic                          self_refresh,
    output logic                          array_power_off_mode,
    output logic                          data_valid,
    output logic                          illegal_cmd
);
    localparam logic [3:0] TRFC = 4'(`LBCS_TRFC_CYC);
    localparam logic [3:0] TMRD = 4'(`LBCS_TMRD_CYC);
    localparam logic [4:0] BURST_CYC = 5'(BL / 2);

    // Pins are from outside; two flops before use
    logic [8+ROW_W:0] s1_q;
    logic [8+ROW_W:0] s2_q;
    logic             cke_prev_q;
    logic             cke_s;
    logic             cs_s;
    logic [2:0]       cmd_s;
    logic [1:0]       ba_s;
    logic [ROW_W-1:0] a_s;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s1_q       <= '0;
            s2_q       <= '0;
            cke_prev_q <= 1'b0;
        end else begin
            s1_q       <= {cke, cs_b, ras_b, cas_b, we_b, bank_addr, addr, 2'b0};
            s2_q       <= s1_q;
            cke_prev_q <= s2_q[8+ROW_W];
        end
    end

    assign cke_s = s2_q[8+ROW_W];
    assign cs_s  = ~s2_q[7+ROW_W];
    assign cmd_s = s2_q[6+ROW_W:4+ROW_W];
    assign ba_s  = s2_q[3+ROW_W:2+ROW_W];
    assign a_s   = s2_q[1+ROW_W:2];

    lbcs_dev_t        dev_q;
    lbcs_dev_t        dev_d;
    logic [3:0]       busy_q;
    logic [3:0]       busy_d;
    logic [ROW_W-1:0] rrow_q;
    logic [ROW_W-1:0] rrow_d;
    logic             valid_q;
    logic             valid_d;
    logic [4:0]       burst_q;
    logic [4:0]       burst_d;
    logic [1:0]       rd_bank_q;
    logic [1:0]       rd_bank_d;
    logic             rd_live_q;
    logic             rd_live_d;
    logic             illegal_q;
    logic             illegal_d;

    logic             run;
    logic             bank_cmd;
    logic [NBANK-1:0] bank_ill;
    logic [NBANK-1:0] bank_idle;
    logic             all_idle;
    logic             is_bst;

    // Bank commands are live only with cke high now and before
    assign run      = dev_q == LBCS_DEV_RUN && cke_s && cke_prev_q
                      && busy_q == 4'h0;
    assign bank_cmd = run && cs_s;
    assign is_bst   = bank_cmd && cmd_s == `LBCS_CMD_BST;
    assign all_idle = &bank_idle;

    lbcs_bank_t st [NBANK];

    genvar gi;
    generate
        for (gi = 0; gi < NBANK; gi++) begin : g_bank
            logic [ROW_W-1:0] row_unused;
            lbcs_bank #(
                .ROW_W (ROW_W)
            ) u_bank (
                .clock      (clock),
                .rst_b      (rst_b),
                .sel        (bank_cmd && ba_s == 2'(gi)),
                .cmd        (cmd_s),
                .ap         (a_s[`LBCS_AP_BIT]),
                .pre_all    (bank_cmd && cmd_s == `LBCS_CMD_PRE
                             && a_s[`LBCS_AP_BIT]),
                .row        (a_s),
                .burst_done (burst_q == 5'h1 && rd_bank_q == 2'(gi)),
                .bst_hit    (is_bst && rd_live_q
                             && rd_bank_q == 2'(gi)),
                .state_q    (st[gi]),
                .row_q      (row_unused),
                .illegal    (bank_ill[gi])
            );
            assign bank_idle[gi] = st[gi] == LBCS_IDLE;
        end
    endgenerate

    always_comb begin
        dev_d     = dev_q;
        busy_d    = (busy_q != 4'h0) ? busy_q - 4'h1 : 4'h0;
        rrow_d    = rrow_q;
        valid_d   = valid_q;
        burst_d   = (burst_q != 5'h0) ? burst_q - 5'h1 : 5'h0;
        rd_bank_d = rd_bank_q;
        rd_live_d = rd_live_q && burst_q != 5'h1;
        illegal_d = 1'b0;
        unique case (dev_q)
            LBCS_DEV_RUN: begin
                if (busy_q == 4'h0 && cke_prev_q && !cke_s && cs_s) begin
                    if (cmd_s == `LBCS_CMD_REF && all_idle)
                        dev_d = LBCS_DEV_SELF_REFRESH;
                    else if (cmd_s == `LBCS_CMD_BST)
                        dev_d = LBCS_DEV_POWER_OFF;
                end
                if (bank_cmd) begin
                    illegal_d = |bank_ill;
                    unique case (cmd_s)
                        `LBCS_CMD_REF: begin
                            if (all_idle) begin
                                dev_d  = LBCS_DEV_REFRESH;
                                busy_d = TRFC;
                                rrow_d = rrow_q + 1'b1;
                            end else
                                illegal_d = 1'b1;
                        end
                        `LBCS_CMD_LMR: begin
                            if (all_idle) begin
                                dev_d  = LBCS_DEV_MODE_REG;
                                busy_d = TMRD;
                            end else
                                illegal_d = 1'b1;
                        end
                        `LBCS_CMD_READ, `LBCS_CMD_WRITE: begin
                            burst_d   = BURST_CYC;
                            rd_bank_d = ba_s;
                            rd_live_d = cmd_s == `LBCS_CMD_READ
                                        && !a_s[`LBCS_AP_BIT];
                        end
                        `LBCS_CMD_BST: begin
                            if (rd_live_q) begin
                                burst_d   = 5'h0;
                                rd_live_d = 1'b0;
                            end else
                                illegal_d = 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
            LBCS_DEV_REFRESH, LBCS_DEV_MODE_REG: begin
                if (busy_q <= 4'h1)
                    dev_d = LBCS_DEV_RUN;
            end
            LBCS_DEV_SELF_REFRESH: begin
                // Only cke is watched here; exit delay left to controller
                if (cke_s)
                    dev_d = LBCS_DEV_RUN;
            end
            LBCS_DEV_POWER_OFF: begin
                valid_d = 1'b0;
                if (cke_s)
                    dev_d = LBCS_DEV_RUN;
            end
            default: dev_d = LBCS_DEV_RUN;
        endcase
        // Any write re-establishes valid contents after power off
        if (bank_cmd && cmd_s == `LBCS_CMD_WRITE)
            valid_d = 1'b1;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dev_q     <= LBCS_DEV_RUN;
            busy_q    <= 4'h0;
            rrow_q    <= `LBCS_ROW_RST;
            valid_q   <= 1'b0;
            burst_q   <= 5'h0;
            rd_bank_q <= 2'h0;
            rd_live_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            dev_q     <= dev_d;
            busy_q    <= busy_d;
            rrow_q    <= rrow_d;
            valid_q   <= valid_d;
            burst_q   <= burst_d;
            rd_bank_q <= rd_bank_d;
            rd_live_q <= rd_live_d;
            illegal_q <= illegal_d;
        end
    end

    // Flop the exported views so every output is registered
    logic [3*NBANK-1:0] bank_state_q;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            bank_state_q <= '0;
        else
            for (int i = 0; i < NBANK; i++)
                bank_state_q[3*i +: 3] <= st[i];
    end

    logic [3:0] flags_q;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            flags_q <= 4'h0;
        else
            flags_q <= {dev_d == LBCS_DEV_REFRESH,
                        dev_d == LBCS_DEV_SELF_REFRESH,
                        dev_d == LBCS_DEV_POWER_OFF, valid_d};
    end

    assign bank_state           = bank_state_q;
    assign refresh_row          = rrow_q;
    assign refresh_busy         = flags_q[3];
    assign self_refresh         = flags_q[2];
    assign array_power_off_mode = flags_q[1];
    assign data_valid           = flags_q[0];
    assign illegal_cmd          = illegal_q;
endmodule : lbcs_ctrl
`default_nettype wire

// *** hw/lbcs_defines.svh ***
`ifndef LBCS_DEFINES_SVH
`define LBCS_DEFINES_SVH

// Timing figures in ns and derived cycle counts at 50 ns
`define LBCS_CLK_NS      50
`define LBCS_TRP_NS      18
`define LBCS_TRCD_NS     18
`define LBCS_TRFC_NS     72
`define LBCS_TMRD_NS     10
`define LBCS_TRP_CYC     ((`LBCS_TRP_NS + `LBCS_CLK_NS - 1) / `LBCS_CLK_NS)
`define LBCS_TRCD_CYC    ((`LBCS_TRCD_NS + `LBCS_CLK_NS - 1) / `LBCS_CLK_NS)
`define LBCS_TRFC_CYC    ((`LBCS_TRFC_NS + `LBCS_CLK_NS - 1) / `LBCS_CLK_NS)
`define LBCS_TMRD_CYC    ((`LBCS_TMRD_NS + `LBCS_CLK_NS - 1) / `LBCS_CLK_NS)

// Command field positions in {ras_b, cas_b, we_b}
`define LBCS_CMD_ACT     3'h3
`define LBCS_CMD_READ    3'h5
`define LBCS_CMD_WRITE   3'h4
`define LBCS_CMD_BST     3'h6
`define LBCS_CMD_PRE     3'h2
`define LBCS_CMD_REF     3'h1
`define LBCS_CMD_LMR     3'h0
`define LBCS_CMD_NOP     3'h7

`define LBCS_AP_BIT      10
`define LBCS_ROW_RST     13'h0000

`endif

// *** hw/lbcs_pkg.sv ***
package lbcs_pkg;
    typedef enum logic [2:0] {
        LBCS_IDLE,
        LBCS_ACTIVATING,
        LBCS_ROW_ACTIVE,
        LBCS_READ,
        LBCS_WRITE,
        LBCS_PRECHARGING,
        LBCS_AP_ACCESS
    } lbcs_bank_t;

    typedef enum logic [2:0] {
        LBCS_DEV_RUN,
        LBCS_DEV_REFRESH,
        LBCS_DEV_MODE_REG,
        LBCS_DEV_SELF_REFRESH,
        LBCS_DEV_POWER_OFF
    } lbcs_dev_t;
endpackage : lbcs_pkg

// *** tb/lbcs_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module lbcs_ctrl_checker
    import lbcs_pkg::*;
#(
    parameter int NBANK = 4,
    parameter int ROW_W = 13,
    parameter int BL    = 4
) (
    input wire logic             clock,
    input wire logic             rst_b,
    input wire logic             cke,
    input wire logic             cs_b,
    input wire logic             ras_b,
    input wire logic             cas_b,
    input wire logic             we_b,
    input wire logic [1:0]       bank_addr,
    input wire logic [ROW_W-1:0] addr,
    input wire logic [3*NBANK-1:0] bank_state,
    input wire logic [ROW_W-1:0] refresh_row,
    input wire logic             refresh_busy,
    input wire logic             self_refresh,
    input wire logic             array_power_off_mode,
    input wire logic             data_valid,
    input wire logic             illegal_cmd
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    wire logic is_ref = !cs_b && !ras_b && !cas_b && we_b;
    wire logic is_bst = !cs_b && ras_b && cas_b && !we_b;
    wire logic is_rd  = !cs_b && ras_b && !cas_b && we_b;
    wire logic [2:0] b0 = bank_state[2:0];

    property p_ref_len;
        $rose(refresh_busy) |-> $past(is_ref && cke, 3) ##0
            refresh_busy[*2] ##1 !refresh_busy;
    endproperty
    a_ref_len: assert property (p_ref_len)
        else $error("refresh busy length wrong");
    property p_ref_row;
        !$stable(refresh_row) && !array_power_off_mode |->
            refresh_row == ROW_W'($past(refresh_row) + 1);
    endproperty
    a_ref_row: assert property (p_ref_row)
        else $error("refresh row not counting by one");
    property p_sr_in;
        $rose(self_refresh) |-> $past(is_ref && !cke, 3);
    endproperty
    a_sr_in: assert property (p_sr_in)
        else $error("self refresh entered without cause");
    property p_sr_hold;
        self_refresh && $past(self_refresh) |->
            $stable(bank_state) && !illegal_cmd;
    endproperty
    a_sr_hold: assert property (p_sr_hold)
        else $error("inputs acted on in self refresh");
    property p_off_in;
        $rose(array_power_off_mode) |-> $past(is_bst && !cke, 3);
    endproperty
    a_off_in: assert property (p_off_in)
        else $error("power off entered without cause");
    property p_off_data;
        array_power_off_mode && $past(array_power_off_mode) |-> !data_valid;
    endproperty
    a_off_data: assert property (p_off_data)
        else $error("data valid in power off");
    property p_ill_cause;
        illegal_cmd |-> $past(!cs_b && cke, 3);
    endproperty
    a_ill_cause: assert property (p_ill_cause)
        else $error("illegal flag without selected command");
    property p_act;
        $rose(b0 == LBCS_ACTIVATING) |=> b0 == LBCS_ROW_ACTIVE;
    endproperty
    a_act: assert property (p_act)
        else $error("activating not one cycle");
    property p_pre;
        $rose(b0 == LBCS_PRECHARGING) |=> b0 == LBCS_IDLE;
    endproperty
    a_pre: assert property (p_pre)
        else $error("precharging not one cycle");
    property p_rd;
        $rose(b0 == LBCS_READ) |-> $past(is_rd, 4);
    endproperty
    a_rd: assert property (p_rd)
        else $error("read state without read command");

    c_ref: cover property ($rose(refresh_busy));
    c_sr: cover property ($rose(self_refresh));
    c_ill: cover property (illegal_cmd);
endmodule : lbcs_ctrl_checker

bind lbcs_ctrl lbcs_ctrl_checker #(
    .NBANK(NBANK),
    .ROW_W(ROW_W),
    .BL(BL)
) u_chk (
    .clock(clock), .rst_b(rst_b), .cke(cke), .cs_b(cs_b),
    .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
    .bank_addr(bank_addr), .addr(addr), .bank_state(bank_state),
    .refresh_row(refresh_row), .refresh_busy(refresh_busy),
    .self_refresh(self_refresh),
    .array_power_off_mode(array_power_off_mode),
    .data_valid(data_valid), .illegal_cmd(illegal_cmd)
);

`default_nettype wire

// *** tb/lbcs_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lbcs_defines.svh"

module lbcs_ctrl_bench
    import lbcs_pkg::*;
();
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        cke, cs_b, ras_b, cas_b, we_b;
    logic [1:0]  bank_addr;
    logic [12:0] addr, refresh_row;
    logic [11:0] bank_state;
    logic        refresh_busy, self_refresh, apm, data_valid, illegal_cmd;
    int          fails = 0;
    int          n_compared = 0;
    int          exp_st[4] = '{default: 0};
    int          exp_row = 0;
    int          k;
    int          seed = 80409;

    // Random column; auto precharge bit kept low so bursts stay open
    function automatic logic [12:0] col();
        return 13'($random(seed)) & 13'h1bff;
    endfunction : col
    logic [2:0]  bad[3] = '{`LBCS_CMD_READ, `LBCS_CMD_WRITE, `LBCS_CMD_BST};

    always #25 clock = ~clock;

    lbcs_host u_host (.clock(clock), .cke(cke), .cs_b(cs_b), .ras_b(ras_b),
        .cas_b(cas_b), .we_b(we_b), .bank_addr(bank_addr), .addr(addr));

    // Long burst so a terminated read is told from a finished one
    lbcs_ctrl #(.BL(16)) DUT (.clock(clock), .rst_b(rst_b), .cke(cke),
        .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
        .bank_addr(bank_addr), .addr(addr), .bank_state(bank_state),
        .refresh_row(refresh_row), .refresh_busy(refresh_busy),
        .self_refresh(self_refresh), .array_power_off_mode(apm),
        .data_valid(data_valid), .illegal_cmd(illegal_cmd));

    task automatic end_of_test;
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic banks;
        @(negedge clock);
        for (int i = 0; i < 4; i++) begin
            chk(13'(bank_state[3*i +: 3]), 13'(exp_st[i]));
        end
    endtask : banks

    task automatic count_ill(output int n);
        n = 0;
        repeat (6) begin
            u_host.idle(1);
            @(negedge clock);
            n += int'(illegal_cmd === 1'b1);
        end
    endtask : count_ill

    task automatic go(input logic [2:0] c, input logic [1:0] b,
                      input logic [12:0] a, input int w);
        u_host.issue(c, b, a, 1'b1);
        u_host.idle(w);
    endtask : go

    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        banks();
        u_host.idle(2);
        exp_st[0] = LBCS_ROW_ACTIVE;
        go(`LBCS_CMD_ACT, 2'h0, 13'h1abc, 7);
        banks();
        exp_st[2] = LBCS_ROW_ACTIVE;
        go(`LBCS_CMD_ACT, 2'h2, 13'h0155, 7);
        banks();
        u_host.issue(`LBCS_CMD_READ, 2'h0, col(), 1'b1);
        exp_st[0] = LBCS_READ;
        go(`LBCS_CMD_BST, 2'h0, col(), 3);
        banks();
        exp_st[0] = LBCS_ROW_ACTIVE;
        u_host.idle(3);
        banks();
        exp_st[0] = LBCS_WRITE;
        go(`LBCS_CMD_WRITE, 2'h0, col(), 4);
        banks();
        exp_st[0] = LBCS_READ;
        go(`LBCS_CMD_READ, 2'h0, 13'h0008, 4);
        banks();
        exp_st[0] = LBCS_PRECHARGING;
        go(`LBCS_CMD_PRE, 2'h0, col(), 4);
        banks();
        exp_st[0] = LBCS_IDLE;
        u_host.idle(1);
        banks();
        exp_st[2] = LBCS_IDLE;
        go(`LBCS_CMD_PRE, 2'h1, 13'h0400, 6);
        banks();
        foreach (bad[i]) begin
            u_host.issue(bad[i], 2'h0, col(), 1'b1);
            count_ill(k);
            chk(13'(k), 13'h0001);
            banks();
        end
        exp_st[1] = LBCS_ROW_ACTIVE;
        go(`LBCS_CMD_ACT, 2'h1, 13'h0777, 7);
        u_host.junk(16, 1'b1, 1'b0);
        count_ill(k);
        chk(13'(k), 13'h0000);
        banks();
        exp_st[1] = LBCS_IDLE;
        go(`LBCS_CMD_PRE, 2'h1, col(), 6);
        chk(13'(data_valid), 13'h0001);
        // Refresh burst ahead of self refresh
        for (int i = 0; i < 2; i++) begin
            go(`LBCS_CMD_REF, 2'(i), 13'(i * 'h1555), 3);
            exp_row++;
            @(negedge clock);
            chk(13'(refresh_busy), 13'h0001);
            u_host.idle(4);
            @(negedge clock);
            chk(13'(refresh_busy), 13'h0000);
            chk(refresh_row, 13'(exp_row));
        end
        u_host.issue(`LBCS_CMD_REF, 2'h0, col(), 1'b0);
        u_host.junk(3, 1'b0, 1'b0);
        @(negedge clock);
        chk(13'(self_refresh), 13'h0001);
        u_host.junk(12, 1'b0, 1'b1);
        banks();
        chk(13'(self_refresh), 13'h0001);
        u_host.idle(8);
        @(negedge clock);
        chk(13'(self_refresh), 13'h0000);
        u_host.issue(`LBCS_CMD_BST, 2'h0, col(), 1'b0);
        u_host.junk(3, 1'b0, 1'b0);
        @(negedge clock);
        chk(13'(apm), 13'h0001);
        u_host.idle(2);
        @(negedge clock);
        chk(13'(data_valid), 13'h0000);
        end_of_test();
    end
endmodule : lbcs_ctrl_bench

`default_nettype wire

// *** tb/lbcs_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lbcs_defines.svh"

module lbcs_host (
    input  wire logic   clock,
    output logic        cke,
    output logic        cs_b,
    output logic        ras_b,
    output logic        cas_b,
    output logic        we_b,
    output logic [1:0]  bank_addr,
    output logic [12:0] addr
);
    int seed = 80409;

    initial begin
        {cke, cs_b, ras_b, cas_b, we_b} = 5'h1f;
        bank_addr = 2'h0;
        addr = 13'h0000;
    end

    // Caller spaces commands past every bank wait
    task automatic issue(input logic [2:0] c, input logic [1:0] b,
                         input logic [12:0] a, input logic ck);
        @(posedge clock);
        cke <= ck;
        cs_b <= 1'b0;
        {ras_b, cas_b, we_b} <= c;
        bank_addr <= b;
        addr <= a;
    endtask : issue

    // Clock enable back high before any command
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clock);
            cke <= 1'b1;
            cs_b <= 1'b0;
            {ras_b, cas_b, we_b} <= `LBCS_CMD_NOP;
            addr <= ~addr;
        end
    endtask : idle

    // Deselect noise, or random commands with random chip select when nz is set; clock enable held low in self refresh
    task automatic junk(input int n, input logic ck, input logic nz);
        repeat (n) begin
            @(posedge clock);
            cke <= ck;
            cs_b <= nz ? 1'($random(seed)) : 1'b1;
            {ras_b, cas_b, we_b} <= 3'($random(seed));
            bank_addr <= 2'($random(seed));
            addr <= 13'($random(seed));
        end
    endtask : junk
endmodule : lbcs_host

`default_nettype wire
